// [src/serial_pkg.sv]
// shared constants, field layout and carrier types of the serial transceiver
package serial_pkg;

    // register byte offsets on the wishbone bus
    localparam logic [7:0]  OFF_MODE     = 8'h00;
    localparam logic [7:0]  OFF_STATUS   = 8'h04;
    localparam logic [7:0]  OFF_TX_DATA  = 8'h08;
    localparam logic [7:0]  OFF_RX_DATA  = 8'h0c;
    localparam logic [7:0]  OFF_BAUD_DIV = 8'h10;

    // serial_mode_config fields
    localparam int          MODE_ENABLE  = 15;
    localparam int          MODE_IR_EN   = 12;
    localparam int          MODE_RX_INV  = 4;
    localparam int          MODE_HISPEED = 3;
    localparam int          MODE_FMT_HI  = 2;
    localparam int          MODE_FMT_LO  = 1;
    localparam int          MODE_STOP2   = 0;
    localparam logic [15:0] MODE_WMASK   = 16'hbbff;
    localparam logic [15:0] MODE_RESET   = 16'h0000;

    // serial_status_control fields
    localparam int          STA_TXI_HI   = 15;
    localparam int          STA_IR_POL   = 14;
    localparam int          STA_TXI_LO   = 13;
    localparam int          STA_BREAK    = 11;
    localparam int          STA_TX_EN    = 10;
    localparam int          STA_RXI_HI   = 7;
    localparam int          STA_RXI_LO   = 6;
    localparam int          STA_ADDR_DET = 5;
    localparam int          STA_OVERRUN  = 1;
    localparam logic [15:0] STA_WMASK    = 16'hece0;
    localparam logic [15:0] STA_RESET    = 16'h0000;
    localparam logic [15:0] BAUD_RESET   = 16'h0000;

    // frame format codes
    localparam logic [1:0]  FMT_9N       = 2'h3;
    localparam logic [1:0]  FMT_8O       = 2'h2;
    localparam logic [1:0]  FMT_8E       = 2'h1;

    // interrupt mode codes
    localparam logic [1:0]  TXI_ANY      = 2'h0;
    localparam logic [1:0]  TXI_DONE     = 2'h1;
    localparam logic [1:0]  TXI_EMPTY    = 2'h2;
    localparam logic [1:0]  RXI_FULL     = 2'h3;
    localparam logic [1:0]  RXI_3Q       = 2'h2;

    // baud ticks per bit, ticks per phase, break length
    localparam logic [3:0]  LAST_PH_STD  = 4'hf;
    localparam logic [3:0]  LAST_PH_HI   = 4'h3;
    localparam logic [3:0]  MID_PH_STD   = 4'h7;
    localparam logic [3:0]  MID_PH_HI    = 4'h1;
    localparam logic [3:0]  IR_PULSE_PH  = 4'h3;
    localparam logic [3:0]  BREAK_LAST   = 4'hb;
    localparam logic [3:0]  DATA9_LAST   = 4'h8;
    localparam logic [3:0]  DATA8_LAST   = 4'h7;

    typedef enum logic [2:0] {
        LS_IDLE  = 3'b000,
        LS_START = 3'b001,
        LS_DATA  = 3'b010,
        LS_PAR   = 3'b011,
        LS_STOP  = 3'b100
    } line_state_t;

    // one receive buffer entry with its own error marks
    typedef struct packed {
        logic       framing_error_flag;
        logic       parity_error_flag;
        logic [8:0] data;
    } rx_entry_t;

endpackage

// [src/serial_transceiver.sv]
// serial transceiver: frame engine, buffers and status behind wishbone
`timescale 1ns/10ps
`default_nettype none

module serial_transceiver #(
    parameter int DEPTH = 4                 // buffer depth, power of two
) (
    input  wire logic        mclk,          // 20 MHz system clock
    input  wire logic        rst_n,         // async reset, active low
    input  wire logic        wb_cyc_i,      // wishbone cycle
    input  wire logic        wb_stb_i,      // wishbone strobe
    input  wire logic        wb_we_i,       // wishbone write
    input  wire logic [7:0]  wb_adr_i,      // byte address
    input  wire logic [3:0]  wb_sel_i,      // byte lanes
    input  wire logic [31:0] wb_dat_i,      // write data
    output logic      [31:0] wb_dat_o,      // read data
    output logic             wb_ack_o,      // acknowledge
    input  wire logic        serial_in_pin, // receive pin, asynchronous
    output logic             serial_out_pin,// transmit pin level
    output logic             serial_out_en_n,// low while block owns pin
    output logic             tx_irq,        // transmit event pulse
    output logic             rx_irq         // receive event pulse
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] THREEQ_CNT = (AW+1)'(DEPTH - 1);

    typedef struct packed {
        logic                            ack;
        logic [31:0]                     rdat;
        logic                            rx_s1;
        logic                            rx_s2;
        logic [15:0]                     mode;
        logic [15:0]                     sta;
        logic [15:0]                     div;
        logic [15:0]                     brg_cnt;
        serial_pkg::line_state_t         tx_st;
        logic [3:0]                      tx_ph;
        logic [3:0]                      tx_bit;
        logic [8:0]                      transmit_shift_reg;
        logic                            tx_brk;
        logic [DEPTH-1:0][8:0]           txb;
        logic [AW-1:0]                   tx_head;
        logic [AW:0]                     tx_cnt;
        logic                            tx_pin;
        logic                            tx_oe_n;
        logic                            tx_irq;
        serial_pkg::line_state_t         rx_st;
        logic [3:0]                      rx_ph;
        logic [3:0]                      rx_bit;
        logic [3:0]                      ir_hold;
        logic [8:0]                      receive_shift_reg;
        logic                            rx_parity_error_flag;
        serial_pkg::rx_entry_t [DEPTH-1:0] rxb;
        logic [AW-1:0]                   rx_head;
        logic [AW:0]                     rx_cnt;
        logic                            overrun;
        logic                            rx_irq;
    } state_t;

    state_t s;
    state_t n;

    // byte-lane merge of a 16-bit register, only writable bits change
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  sel,
                                            input logic [15:0] wmask);
        logic [15:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & wmask;
        return (old & ~lane) | (wd & lane);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        logic        en;
        logic        tick;
        logic        hs;
        logic        ir_on;
        logic [3:0]  last_ph;
        logic [3:0]  mid_ph;
        logic [1:0]  fmt;
        logic        nine;
        logic        par_on;
        logic        req;
        logic        wr;
        logic        rd;
        logic        tx_push;
        logic        tx_pop;
        logic        tx_end;
        logic        line;
        logic        rx_raw;
        logic        rx_line;
        logic        rx_push;
        logic        rx_pop;
        logic        rx_flush;
        logic [3:0]  dlast;
        logic [15:0] sta_rd;
        serial_pkg::rx_entry_t head;
        en       = 1'b0;
        tick     = 1'b0;
        hs       = 1'b0;
        ir_on    = 1'b0;
        last_ph  = 4'h0;
        mid_ph   = 4'h0;
        fmt      = 2'h0;
        nine     = 1'b0;
        par_on   = 1'b0;
        req      = 1'b0;
        wr       = 1'b0;
        rd       = 1'b0;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        tx_end   = 1'b0;
        line     = 1'b1;
        rx_raw   = 1'b1;
        rx_line  = 1'b1;
        rx_push  = 1'b0;
        rx_pop   = 1'b0;
        rx_flush = 1'b0;
        dlast    = 4'h0;
        sta_rd   = 16'h0000;
        head     = '0;
        n        = s;
        n.tx_irq = 1'b0;
        n.rx_irq = 1'b0;

        // configuration decode
        en      = s.mode[serial_pkg::MODE_ENABLE];
        hs      = s.mode[serial_pkg::MODE_HISPEED];
        last_ph = hs ? serial_pkg::LAST_PH_HI : serial_pkg::LAST_PH_STD;
        mid_ph  = hs ? serial_pkg::MID_PH_HI : serial_pkg::MID_PH_STD;
        ir_on   = s.mode[serial_pkg::MODE_IR_EN] && !hs;
        fmt     = s.mode[serial_pkg::MODE_FMT_HI:serial_pkg::MODE_FMT_LO];
        nine    = (fmt == serial_pkg::FMT_9N);
        par_on  = (fmt == serial_pkg::FMT_8O) || (fmt == serial_pkg::FMT_8E);
        dlast   = nine ? serial_pkg::DATA9_LAST : serial_pkg::DATA8_LAST;

        // baud generator: one tick every div+1 clocks, stopped when off
        tick      = en && (s.brg_cnt == s.div);
        n.brg_cnt = (tick || !en) ? 16'h0000 : s.brg_cnt + 16'h0001;

        // rx pin goes through two flops before anything looks at it
        n.rx_s1 = serial_in_pin;
        n.rx_s2 = s.rx_s1;
        rx_raw  = s.rx_s2 ^ s.mode[serial_pkg::MODE_RX_INV];
        // ir decoder stretches each short pulse into a whole low bit
        if (ir_on && rx_raw)
            n.ir_hold = last_ph;
        else if (tick && s.ir_hold != 4'h0)
            n.ir_hold = s.ir_hold - 4'h1;
        rx_line = ir_on ? !(rx_raw || s.ir_hold != 4'h0) : rx_raw;

        // bus access, answered one clock after the request appears
        req   = wb_cyc_i && wb_stb_i && !s.ack;
        wr    = req && wb_we_i;
        rd    = req && !wb_we_i;
        n.ack = req;
        head  = s.rxb[s.rx_head];
        sta_rd = s.sta & serial_pkg::STA_WMASK;
        sta_rd[9] = (s.tx_cnt == FULL_CNT);
        sta_rd[8] = (s.tx_st == serial_pkg::LS_IDLE) && (s.tx_cnt == '0);
        sta_rd[4] = (s.rx_st == serial_pkg::LS_IDLE);
        sta_rd[3] = (s.rx_cnt != '0) && head.parity_error_flag;
        sta_rd[2] = (s.rx_cnt != '0) && head.framing_error_flag;
        sta_rd[1] = s.overrun;
        sta_rd[0] = (s.rx_cnt != '0);
        n.rdat = 32'h0000_0000;
        if (rd)
        begin
            case (wb_adr_i)
                serial_pkg::OFF_MODE:     n.rdat = {16'h0000, s.mode};
                serial_pkg::OFF_STATUS:   n.rdat = {16'h0000, sta_rd};
                serial_pkg::OFF_RX_DATA:  n.rdat = {23'h000000, head.data};
                serial_pkg::OFF_BAUD_DIV: n.rdat = {16'h0000, s.div};
                default:                  n.rdat = 32'h0000_0000;
            endcase
            rx_pop = (wb_adr_i == serial_pkg::OFF_RX_DATA)
                     && (s.rx_cnt != '0);
        end
        if (wr)
        begin
            case (wb_adr_i)
                serial_pkg::OFF_MODE:
                    n.mode = merge16(s.mode, wb_dat_i[15:0], wb_sel_i[1:0],
                                     serial_pkg::MODE_WMASK);
                serial_pkg::OFF_BAUD_DIV:
                    n.div = merge16(s.div, wb_dat_i[15:0], wb_sel_i[1:0],
                                    16'hffff);
                serial_pkg::OFF_TX_DATA:
                    tx_push = en && wb_sel_i[0] && (s.tx_cnt != FULL_CNT);
                default:
                    n.div = s.div;
            endcase
            // software may only clear overrun; a 1 to 0 flushes receiver
            if (wb_adr_i == serial_pkg::OFF_STATUS && wb_sel_i[0]
                && s.overrun && !wb_dat_i[serial_pkg::STA_OVERRUN])
            begin
                n.overrun = 1'b0;
                rx_flush  = 1'b1;
            end
        end

        ////////////////////////////////////////////////////////////////
        // transmitter
        line = 1'b1;
        if (s.tx_st != serial_pkg::LS_IDLE && tick)
            n.tx_ph = (s.tx_ph == last_ph) ? 4'h0 : s.tx_ph + 4'h1;
        tx_end = tick && (s.tx_ph == last_ph);
        case (s.tx_st)
            serial_pkg::LS_IDLE:
            begin
                if (s.sta[serial_pkg::STA_TX_EN] && s.tx_cnt != '0)
                begin
                    tx_pop   = 1'b1;
                    n.transmit_shift_reg    = s.txb[s.tx_head];
                    n.tx_brk = s.sta[serial_pkg::STA_BREAK];
                    n.tx_ph  = 4'h0;
                    n.tx_st  = serial_pkg::LS_START;
                    case ({s.sta[serial_pkg::STA_TXI_HI],
                           s.sta[serial_pkg::STA_TXI_LO]})
                        serial_pkg::TXI_ANY:   n.tx_irq = 1'b1;
                        serial_pkg::TXI_EMPTY:
                            n.tx_irq = (s.tx_cnt == (AW+1)'(1)) && !tx_push;
                        default:               n.tx_irq = 1'b0;
                    endcase
                end
            end
            serial_pkg::LS_START:
            begin
                line = 1'b0;
                if (tx_end)
                begin
                    n.tx_bit = 4'h0;
                    n.tx_st  = serial_pkg::LS_DATA;
                end
            end
            serial_pkg::LS_DATA:
            begin
                // break sends zeros in place of data, lsb first otherwise
                line = s.tx_brk ? 1'b0 : s.transmit_shift_reg[s.tx_bit];
                if (tx_end)
                begin
                    n.tx_bit = s.tx_bit + 4'h1;
                    if (s.tx_bit == (s.tx_brk ? serial_pkg::BREAK_LAST
                                              : dlast))
                    begin
                        n.tx_bit = 4'h0;
                        n.tx_st  = (par_on && !s.tx_brk) ? serial_pkg::LS_PAR
                                                         : serial_pkg::LS_STOP;
                    end
                end
            end
            serial_pkg::LS_PAR:
            begin
                line = (fmt == serial_pkg::FMT_8O) ? ~^s.transmit_shift_reg[7:0]
                                                   : ^s.transmit_shift_reg[7:0];
                if (tx_end)
                    n.tx_st = serial_pkg::LS_STOP;
            end
            serial_pkg::LS_STOP:
            begin
                line = 1'b1;
                if (tx_end)
                begin
                    n.tx_bit = s.tx_bit + 4'h1;
                    if (s.tx_bit == {3'h0, s.mode[serial_pkg::MODE_STOP2]})
                    begin
                        n.tx_st = serial_pkg::LS_IDLE;
                        if (s.tx_brk)
                            n.sta[serial_pkg::STA_BREAK] = 1'b0;
                        n.tx_irq = ({s.sta[serial_pkg::STA_TXI_HI],
                                     s.sta[serial_pkg::STA_TXI_LO]}
                                    == serial_pkg::TXI_DONE)
                                   && (s.tx_cnt == '0) && !tx_push;
                    end
                end
            end
            default: n.tx_st = serial_pkg::LS_IDLE;
        endcase

        // status control writes land after the break self-clear
        if (wr && wb_adr_i == serial_pkg::OFF_STATUS)
            n.sta = merge16(n.sta, wb_dat_i[15:0], wb_sel_i[1:0],
                            serial_pkg::STA_WMASK);

        // transmit buffer ring: push at tail, pop at head
        if (tx_push)
            n.txb[s.tx_head + s.tx_cnt[AW-1:0]] = wb_dat_i[8:0];
        if (tx_pop)
            n.tx_head = s.tx_head + AW'(1);
        n.tx_cnt = s.tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);

        // pin: ir pulse is the first 3/16 of each low bit
        if (ir_on)
            n.tx_pin = (!line && s.tx_st != serial_pkg::LS_IDLE
                        && s.tx_ph < serial_pkg::IR_PULSE_PH)
                       ? !s.sta[serial_pkg::STA_IR_POL]
                       : s.sta[serial_pkg::STA_IR_POL];
        else
            n.tx_pin = line;
        n.tx_oe_n = !(en && s.sta[serial_pkg::STA_TX_EN]);

        // tx enable clear aborts the frame and empties the buffer
        if (!s.sta[serial_pkg::STA_TX_EN] || !en)
        begin
            n.tx_st   = serial_pkg::LS_IDLE;
            n.tx_cnt  = '0;
            n.tx_head = '0;
            n.tx_irq  = 1'b0;
        end

        ////////////////////////////////////////////////////////////////
        // receiver, sampling in the middle of each bit
        if (s.rx_st != serial_pkg::LS_IDLE && tick)
            n.rx_ph = s.rx_ph + 4'h1;
        case (s.rx_st)
            serial_pkg::LS_IDLE:
            begin
                n.rx_ph = 4'h0;
                if (!rx_line)
                    n.rx_st = serial_pkg::LS_START;
            end
            serial_pkg::LS_START:
            begin
                if (tick && s.rx_ph == mid_ph)
                begin
                    // a start that is gone by mid-bit was a glitch
                    n.rx_st  = rx_line ? serial_pkg::LS_IDLE
                                       : serial_pkg::LS_DATA;
                    n.rx_ph  = 4'h0;
                    n.rx_bit = 4'h0;
                    n.receive_shift_reg    = 9'h000;
                end
            end
            serial_pkg::LS_DATA:
            begin
                if (tick && s.rx_ph == last_ph)
                begin
                    n.rx_ph           = 4'h0;
                    n.receive_shift_reg[s.rx_bit]   = rx_line;
                    n.rx_bit          = s.rx_bit + 4'h1;
                    if (s.rx_bit == dlast)
                        n.rx_st = par_on ? serial_pkg::LS_PAR
                                         : serial_pkg::LS_STOP;
                    n.rx_parity_error_flag = 1'b0;
                end
            end
            serial_pkg::LS_PAR:
            begin
                if (tick && s.rx_ph == last_ph)
                begin
                    n.rx_ph   = 4'h0;
                    n.rx_parity_error_flag = rx_line != ((fmt == serial_pkg::FMT_8O)
                                            ? ~^s.receive_shift_reg[7:0] : ^s.receive_shift_reg[7:0]);
                    n.rx_st   = serial_pkg::LS_STOP;
                end
            end
            serial_pkg::LS_STOP:
            begin
                if (tick && s.rx_ph == last_ph)
                begin
                    n.rx_st = serial_pkg::LS_IDLE;
                    // address detect drops 9-bit format characters with bit 8 clear
                    rx_push = !(s.sta[serial_pkg::STA_ADDR_DET] && nine
                                && !s.receive_shift_reg[8]);
                end
            end
            default: n.rx_st = serial_pkg::LS_IDLE;
        endcase

        // receive buffer ring; a full buffer loses the new character
        if (rx_push && (s.rx_cnt - (AW+1)'(rx_pop)) == FULL_CNT)
        begin
            n.overrun = 1'b1;
            rx_push   = 1'b0;
        end
        if (rx_push)
        begin
            n.rxb[s.rx_head + s.rx_cnt[AW-1:0]] =
                {!rx_line, s.rx_parity_error_flag, s.receive_shift_reg};
            case (s.sta[serial_pkg::STA_RXI_HI:serial_pkg::STA_RXI_LO])
                serial_pkg::RXI_FULL:
                    n.rx_irq = (s.rx_cnt - (AW+1)'(rx_pop)) == THREEQ_CNT;
                serial_pkg::RXI_3Q:
                    n.rx_irq = (s.rx_cnt - (AW+1)'(rx_pop))
                               == (THREEQ_CNT - (AW+1)'(1));
                default:
                    n.rx_irq = 1'b1;
            endcase
        end
        if (rx_pop)
            n.rx_head = s.rx_head + AW'(1);
        n.rx_cnt = s.rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
        if (rx_flush || !en)
        begin
            n.rx_cnt  = '0;
            n.rx_head = '0;
            n.rx_st   = serial_pkg::LS_IDLE;
            n.rx_irq  = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // the whole block state in one register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s         <= '0;
            s.mode    <= serial_pkg::MODE_RESET;
            s.sta     <= serial_pkg::STA_RESET;
            s.div     <= serial_pkg::BAUD_RESET;
            s.rx_s1   <= 1'b1;
            s.rx_s2   <= 1'b1;
            s.tx_st   <= serial_pkg::LS_IDLE;
            s.rx_st   <= serial_pkg::LS_IDLE;
            s.tx_pin  <= 1'b1;
            s.tx_oe_n <= 1'b1;
        end
        else
            s <= n;
    end

    // outputs straight from the state register
    assign wb_dat_o        = s.rdat;
    assign wb_ack_o        = s.ack;
    assign serial_out_pin  = s.tx_pin;
    assign serial_out_en_n = s.tx_oe_n;
    assign tx_irq          = s.tx_irq;
    assign rx_irq          = s.rx_irq;

endmodule
`default_nettype wire

// [testbench/serial_transceiver_assertions.sv]
// bus and event checks on the serial transceiver ports
`timescale 1ns/10ps
`default_nettype none
module serial_checker (
    input wire logic        mclk, rst_n,            // clock, reset
    input wire logic        wb_cyc_i, wb_stb_i,     // cycle, strobe
    input wire logic        wb_we_i, wb_ack_o,      // write, ack
    input wire logic [7:0]  wb_adr_i,               // address
    input wire logic [3:0]  wb_sel_i,               // lanes
    input wire logic [31:0] wb_dat_i, wb_dat_o,     // data
    input wire logic        serial_in_pin, serial_out_pin, // line
    input wire logic        serial_out_en_n, tx_irq, rx_irq // outputs
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////
    // a new request and a read answer
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_rd; wb_ack_o && !wb_we_i; endsequence
    a_ack_after_req: assert property (s_req |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (s_rd |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper half not zero");
    a_unmapped_zero: assert property (s_rd ##0 wb_adr_i > 8'h10
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_full_not_empty: assert property (s_rd ##0 wb_adr_i == 8'h04
        && wb_dat_o[9] |-> !wb_dat_o[8]) else $error("full and empty");
    a_tx_irq_pulse: assert property (tx_irq |=> !tx_irq)
        else $error("tx event longer than one cycle");
    a_rx_irq_pulse: assert property (rx_irq |=> !rx_irq)
        else $error("rx event longer than one cycle");
endmodule
bind serial_transceiver serial_checker i_chk (.*);
`default_nettype wire

// [testbench/serial_remote.sv]
// remote transceiver model driving the receive line
`timescale 1ns/10ps
`default_nettype none
module serial_remote (
    input  wire logic mclk, // system clock
    output logic      line  // line into the block, idle high
);
    initial line = 1'b1;
    // frame lsb first, padded with idle ones to eleven bits
    function automatic logic [10:0] frame(input logic [8:0] d,
                                          input logic [1:0] fm);
        logic p;
        p = ^d[7:0] ^ (fm == 2'h2);
        return fm == 2'h3 ? {1'b1, d, 1'b0} : fm == 2'h0 ?
            {2'h3, d[7:0], 1'b0} : {1'b1, p, d[7:0], 1'b0};
    endfunction
    // one character, each bit held bc clocks
    task automatic send(input logic [8:0] d, input logic [1:0] fm,
                        input int bc);
        for (int k = 0; k < 11; k++)
        begin
            line <= 1'(frame(d, fm) >> k);
            repeat (bc) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

// [testbench/uart_frame_and_status_logic_tb_top.sv]
// self-checking bench of the serial transceiver
`timescale 1ns/10ps
`default_nettype none
module uart_frame_and_status_logic_tb_top;
    logic        mclk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0, wb_we_i = 1'b0, serial_in_pin;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, serial_out_pin, serial_out_en_n, tx_irq, rx_irq;
    logic [12:0] f;
    logic [8:0]  d;
    logic [1:0]  fm;
    int unsigned rs = 69;
    int          errors = 0, samples_checked = 0, bc;
    int          tx_ev = 0, rx_ev = 0;
    always #25 mclk = ~mclk;
    serial_transceiver i_dut (.*);
    serial_remote i_far (.mclk(mclk), .line(serial_in_pin));
    // event pulses stand one cycle, so a count per edge sees each once
    always @(posedge mclk)
    begin
        tx_ev <= tx_ev + int'(tx_irq);
        rx_ev <= rx_ev + int'(rx_irq);
    end
    ////////////////////////////////////////////////////////////////////
    // xorshift stimulus source
    function int unsigned rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // classic cycle held until ack is sampled, then released
    task bus(input logic w, input logic [7:0] a, input logic [15:0] v);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, 4'h3, 16'h0, v};
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // waits for a start bit, then samples n bits mid-bit
    task watch_tx(input int n);
        while (serial_out_pin !== 1'b0) @(posedge mclk);
        repeat (bc / 2) @(posedge mclk);
        for (int k = 0; k < n; k++)
        begin
            check(32'(serial_out_pin), 32'(f[k]));
            repeat (bc) @(posedge mclk);
        end
    endtask
    task final_report();
        $display("errors %0d, samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // a hang is cut short well beyond the expected run
    initial
    begin
        repeat (60000) @(posedge mclk);
        errors++;
        final_report();
    end
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        bus(0, serial_pkg::OFF_MODE, 0);
        check(q, 32'h0);
        bus(0, serial_pkg::OFF_STATUS, 0);
        check(q, 32'h110);
        bus(0, 8'h14, 0);
        check(q, 32'h0);
        check(32'(serial_out_en_n), 32'h1);
        // every format at both oversampling rates, both directions
        for (int i = 0; i < 8; i++)
        begin
            fm = i[1:0];
            bc = i[2] ? 4 : 16;
            d = 9'(rnd());
            bus(1, serial_pkg::OFF_MODE, {12'h800, i[2], fm, 1'b0});
            bus(1, serial_pkg::OFF_STATUS, 16'h0400);
            // the enable output follows one clock after the write lands
            @(posedge mclk);
            check(32'(serial_out_en_n), 32'h0);
            bus(1, serial_pkg::OFF_TX_DATA, 16'(d));
            f = 13'(i_far.frame(d, fm));
            watch_tx(11);
            bus(0, serial_pkg::OFF_STATUS, 0);
            check(q & 32'h300, 32'h100);
            i_far.send(d, fm, bc);
            repeat (bc) @(posedge mclk);
            bus(0, serial_pkg::OFF_STATUS, 0);
            check(q & 32'hd, 32'h1);
            bus(0, serial_pkg::OFF_RX_DATA, 0);
            check(q, 32'(fm == 2'h3 ? d : {1'b0, d[7:0]}));
            bus(0, serial_pkg::OFF_STATUS, 0);
            check(q & 32'h1, 32'h0);
        end
        // break: start, twelve zeros, stop, then the bit clears
        // done event mode: one pulse once the break has left the pin
        bus(1, serial_pkg::OFF_STATUS, 16'h2c00);
        bus(1, serial_pkg::OFF_TX_DATA, 16'h55);
        f = 13'h0;
        watch_tx(13);
        check(32'(serial_out_pin), 32'h1);
        repeat (bc * 2) @(posedge mclk);
        bus(0, serial_pkg::OFF_STATUS, 0);
        check(q & 32'h800, 32'h0);
        // five characters into four places, then clear the overrun
        bus(1, serial_pkg::OFF_STATUS, 16'h04c0);
        for (int k = 0; k < 5; k++)
            i_far.send(9'(k + 1), 2'h3, bc);
        repeat (bc) @(posedge mclk);
        bus(0, serial_pkg::OFF_STATUS, 0);
        check(q & 32'h3, 32'h3);
        // the lost fifth character must leave the oldest one at the head
        bus(0, serial_pkg::OFF_RX_DATA, 0);
        check(q, 32'h1);
        bus(1, serial_pkg::OFF_STATUS, 16'h0400);
        bus(0, serial_pkg::OFF_STATUS, 0);
        check(q & 32'h3, 32'h0);
        // eight loads and the break done; eight characters and the fill
        check(tx_ev, 32'h9);
        check(rx_ev, 32'h9);
        final_report();
    end
endmodule
`default_nettype wire
